// file: logic/usb_cfg_defs.vh
`ifndef USB_CFG_DEFS_VH
`define USB_CFG_DEFS_VH

// register byte offsets and the endpoint base word index
`define UCF_OFS_FLAGS      12'h000
`define UCF_OFS_EP_BASE    12'h020
`define UCF_WORD_EP_BASE   6'h08

// build feature flag bit positions
`define UCF_BIT_RX_COMBINE 7
`define UCF_BIT_TX_SPLIT   6
`define UCF_BIT_BYTE_ORDER 5
`define UCF_BIT_HB_RX      4
`define UCF_BIT_HB_TX      3
`define UCF_BIT_RESIZE     2
`define UCF_BIT_SOFT_ATT   1
`define UCF_BIT_PHY_WIDTH  0

// build feature flag reset values
`define UCF_RST_RX_COMBINE 1'h0
`define UCF_RST_TX_SPLIT   1'h0
`define UCF_RST_BYTE_ORDER 1'h0
`define UCF_RST_HB_RX      1'h0
`define UCF_RST_HB_TX      1'h0
`define UCF_RST_RESIZE     1'h1
`define UCF_RST_SOFT_ATT   1'h1
`define UCF_RST_PHY_WIDTH  1'h0

// fifo port reset value and receive fifo depth (log2)
`define UCF_RST_EP_DATA    32'h0000_0000
`define UCF_RX_AW          4

`endif

// file: logic/ep_fifo_mem.v
// simple dual port word store, registered read data
module ep_fifo_mem #(
   parameter DW = 32,
   parameter AW = 7
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata_r
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // storage has no reset; only the read register does
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // read data held until the next read
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= {DW{1'b0}};
      end else if (re) begin
         rdata_r <= mem[raddr];
      end
   end

endmodule // ep_fifo_mem

// file: logic/usb_cfg_fifo_ports.v
// Notes on behaviour
// - feature flags read-only, resize/attach set, writes ignored
// - bit 7 reports bulk receive combining
// - bit 6 reports bulk transmit splitting
// - bit 5 reports byte order, one big
// - bit 4 reports high-bandwidth iso receive
// - bit 3 reports high-bandwidth iso transmit
// - bit 2 reports fifo resizing support
// - bit 1 reports soft attach support
// - bit 0 reports phy path width
// - five 32-bit fifo ports, own addresses
// - port write pushes into transmit fifo
// - port read pops receive fifo word
//
// Our own choices: the address map and the APB interface to the registers.
`include "usb_cfg_defs.vh"

module usb_cfg_fifo_ports #(
   parameter       ADDR_W       = 12,
   parameter       NUM_EP       = 5,
   parameter       RX_AW        = `UCF_RX_AW,
   parameter [0:0] RX_COMBINE   = `UCF_RST_RX_COMBINE,
   parameter [0:0] TX_SPLIT     = `UCF_RST_TX_SPLIT,
   parameter [0:0] BYTE_ORDER   = `UCF_RST_BYTE_ORDER,
   parameter [0:0] HB_RX        = `UCF_RST_HB_RX,
   parameter [0:0] HB_TX        = `UCF_RST_HB_TX,
   parameter [0:0] RESIZE       = `UCF_RST_RESIZE,
   parameter [0:0] SOFT_ATT     = `UCF_RST_SOFT_ATT,
   parameter [0:0] PHY_WIDTH    = `UCF_RST_PHY_WIDTH
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output wire [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire [NUM_EP-1:0] tx_full,
   output wire [NUM_EP-1:0] tx_push,
   output wire [31:0]       tx_data,
   input  wire              rx_wr_valid,
   input  wire [2:0]        rx_wr_ep,
   input  wire [31:0]       rx_wr_data,
   output wire [NUM_EP-1:0] rx_full,
   output wire [NUM_EP-1:0] rx_empty
);

   localparam ST_IDLE   = 3'b001;
   localparam ST_RDWAIT = 3'b010;
   localparam ST_DONE   = 3'b100;
   localparam MEM_AW    = 3 + RX_AW;
   localparam [RX_AW:0] RX_DEPTH = {1'b1, {RX_AW{1'b0}}};

   reg  [2:0]        state_r;
   reg  [2:0]        state_nxt;
   reg  [31:0]       prdata_r;
   reg  [31:0]       prdata_nxt;
   reg               pready_r;
   reg               pready_nxt;
   reg               pslverr_r;
   reg               pslverr_nxt;
   reg  [NUM_EP-1:0] tx_push_r;
   reg  [NUM_EP-1:0] tx_push_nxt;
   reg  [31:0]       tx_data_r;
   reg  [31:0]       tx_data_nxt;
   reg  [NUM_EP-1:0] pop_ep;
   reg  [7:0]        flags_r;

   wire [NUM_EP*RX_AW-1:0] rd_ptr_all;
   wire [NUM_EP*RX_AW-1:0] wr_ptr_all;
   wire [NUM_EP-1:0]       rx_ok_all;
   wire [NUM_EP-1:0]       rx_empty_all;
   wire [31:0]             mem_rdata;

   // word index decode; only word addresses are compared
   wire [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
   wire              hit_flags = (word_idx == `UCF_OFS_FLAGS >> 2);
   wire [ADDR_W-3:0] ep_off = word_idx - `UCF_WORD_EP_BASE;
   wire              hit_ep = (word_idx >= `UCF_WORD_EP_BASE) &&
                              (ep_off < NUM_EP);
   wire [2:0]        ep_sel = ep_off[2:0];
   wire              access = psel && penable && (state_r == ST_IDLE);

   // receive writer targets a real, non-full endpoint
   wire              rx_we = rx_wr_valid && (rx_wr_ep < NUM_EP) &&
                             rx_ok_all[rx_wr_ep];
   wire [RX_AW-1:0]  wr_ptr_sel = wr_ptr_all[rx_wr_ep*RX_AW +: RX_AW];
   wire [RX_AW-1:0]  rd_ptr_sel = rd_ptr_all[ep_sel*RX_AW +: RX_AW];

   // feature flags are fixed at build time; a strap is never sampled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= 8'h00;
         flags_r[`UCF_BIT_RX_COMBINE] <= RX_COMBINE;
         flags_r[`UCF_BIT_TX_SPLIT]   <= TX_SPLIT;
         flags_r[`UCF_BIT_BYTE_ORDER] <= BYTE_ORDER;
         flags_r[`UCF_BIT_HB_RX]      <= HB_RX;
         flags_r[`UCF_BIT_HB_TX]      <= HB_TX;
         flags_r[`UCF_BIT_RESIZE]     <= RESIZE;
         flags_r[`UCF_BIT_SOFT_ATT]   <= SOFT_ATT;
         flags_r[`UCF_BIT_PHY_WIDTH]  <= PHY_WIDTH;
      end else begin
         flags_r <= flags_r;
      end
   end

   // bus answer; one wait state, two for a fifo read with data
   always @* begin
      state_nxt   = state_r;
      prdata_nxt  = prdata_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      tx_push_nxt = {NUM_EP{1'b0}};
      tx_data_nxt = tx_data_r;
      pop_ep      = {NUM_EP{1'b0}};
      case (state_r)
         ST_IDLE: begin
            if (access) begin
               state_nxt  = ST_DONE;
               pready_nxt = 1'b1;
               prdata_nxt = 32'h0000_0000;
               if (hit_flags) begin
                  if (!pwrite) begin
                     prdata_nxt = {24'h00_0000, flags_r};
                  end
               end else if (hit_ep && pwrite) begin
                  // a full transmit fifo refuses the word with an error
                  if (tx_full[ep_sel]) begin
                     pslverr_nxt = 1'b1;
                  end else begin
                     tx_push_nxt[ep_sel] = 1'b1;
                     tx_data_nxt         = pwdata;
                  end
               end else if (hit_ep) begin
                  if (!rx_empty_all[ep_sel]) begin
                     pop_ep[ep_sel] = 1'b1;
                     state_nxt      = ST_RDWAIT;
                     pready_nxt     = 1'b0;
                  end
                  // empty: zero returned, nothing popped
               end else begin
                  pslverr_nxt = 1'b1;
               end
            end
         end
         ST_RDWAIT: begin
            state_nxt  = ST_DONE;
            pready_nxt = 1'b1;
            prdata_nxt = mem_rdata;
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // bus side registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= ST_IDLE;
         prdata_r  <= `UCF_RST_EP_DATA;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         tx_push_r <= {NUM_EP{1'b0}};
         tx_data_r <= `UCF_RST_EP_DATA;
      end else begin
         state_r   <= state_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         tx_push_r <= tx_push_nxt;
         tx_data_r <= tx_data_nxt;
      end
   end

   // per endpoint receive pointers and level
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g = g + 1) begin : g_rx
         reg  [RX_AW-1:0] rd_ptr_r;
         reg  [RX_AW-1:0] wr_ptr_r;
         reg  [RX_AW:0]   cnt_r;
         reg  [RX_AW:0]   cnt_nxt;
         reg              full_r;
         reg              empty_r;
         wire             push = rx_we && (rx_wr_ep == g);
         wire             pop  = pop_ep[g];

         always @* begin
            cnt_nxt = cnt_r;
            if (push && !pop) begin
               cnt_nxt = cnt_r + 1'b1;
            end else if (pop && !push) begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end

         // pointers move only on a real push or pop
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rd_ptr_r <= {RX_AW{1'b0}};
               wr_ptr_r <= {RX_AW{1'b0}};
               cnt_r    <= {(RX_AW+1){1'b0}};
               full_r   <= 1'b0;
               empty_r  <= 1'b1;
            end else begin
               if (pop) begin
                  rd_ptr_r <= rd_ptr_r + 1'b1;
               end
               if (push) begin
                  wr_ptr_r <= wr_ptr_r + 1'b1;
               end
               cnt_r   <= cnt_nxt;
               full_r  <= (cnt_nxt == RX_DEPTH);
               empty_r <= (cnt_nxt == {(RX_AW+1){1'b0}});
            end
         end

         assign rd_ptr_all[g*RX_AW +: RX_AW] = rd_ptr_r;
         assign wr_ptr_all[g*RX_AW +: RX_AW] = wr_ptr_r;
         assign rx_ok_all[g]    = !full_r;
         assign rx_empty_all[g] = empty_r;
         assign rx_full[g]      = full_r;
         assign rx_empty[g]     = empty_r;
      end
   endgenerate

   // endpoint number forms the upper address bits of the store
   ep_fifo_mem #(
      .DW (32),
      .AW (MEM_AW)
   ) u_rx_mem (
      .clk     (pclk),
      .rst_n   (presetn),
      .we      (rx_we),
      .waddr   ({rx_wr_ep, wr_ptr_sel}),
      .wdata   (rx_wr_data),
      .re      (|pop_ep),
      .raddr   ({ep_sel, rd_ptr_sel}),
      .rdata_r (mem_rdata)
   );

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign tx_push = tx_push_r;
   assign tx_data = tx_data_r;

endmodule // usb_cfg_fifo_ports

// file: sim/usb_cfg_fifo_ports_sva.sv
module usb_cfg_fifo_ports_sva (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [4:0]  tx_full,
   input wire [4:0]  tx_push,
   input wire [31:0] tx_data,
   input wire        rx_wr_valid,
   input wire [2:0]  rx_wr_ep,
   input wire [4:0]  rx_empty
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       acc_r;
   logic       take;
   logic       hit;
   logic [9:0] w;
   logic [2:0] ep;
   // word index, endpoint decode and first access edge only
   assign w    = paddr[11:2];
   assign hit  = (w >= 10'h008) && (w <= 10'h00C);
   assign ep   = 3'(w - 10'h008);
   assign take = psel && penable && !pready && !acc_r;
   // remembers a pending access so waits are not taken twice
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) acc_r <= 1'b0;
      else acc_r <= psel && penable && !pready;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_slow; !pready ##1 pready; endsequence
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_flags_read: assert property (take && !pwrite && w == 10'h000 |=> pready && !pslverr && prdata == 32'h0000_0006)
      else $error("flags read wrong");
   a_flags_ro: assert property (take && pwrite && w == 10'h000 |=> pready && !pslverr && tx_push == 5'h00)
      else $error("flags write not ignored");
   a_unmapped_err: assert property (take && w != 10'h000 && !hit |=> pready && pslverr) else $error("unmapped no error");
   a_push_word: assert property (take && pwrite && hit && !tx_full[ep] |=>
      tx_push == (5'h01 << $past(ep)) && tx_data == $past(pwdata) && !pslverr) else $error("push wrong");
   a_full_refused: assert property (take && pwrite && hit && tx_full[ep] |=> pslverr && tx_push == 5'h00)
      else $error("full push not refused");
   a_push_cause: assert property (tx_push != 5'h00 |-> $past(take) && $past(pwrite)) else $error("stray push");
   a_empty_zero: assert property (take && !pwrite && hit && rx_empty[ep] |=> pready && prdata == 32'h0 && !pslverr)
      else $error("empty read wrong");
   a_pop_slow: assert property (take && !pwrite && hit && !rx_empty[ep] |=> s_slow) else $error("pop timing");
   a_rx_store: assert property (rx_wr_valid && rx_wr_ep < 3'h5 |=> !rx_empty[$past(rx_wr_ep)])
      else $error("rx word lost");
endmodule // usb_cfg_fifo_ports_sva
bind usb_cfg_fifo_ports usb_cfg_fifo_ports_sva i_usb_cfg_fifo_ports_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_full(tx_full), .tx_push(tx_push), .tx_data(tx_data),
   .rx_wr_valid(rx_wr_valid), .rx_wr_ep(rx_wr_ep), .rx_empty(rx_empty));

// file: sim/usb_cfg_fifo_ports_test.sv
`include "usb_cfg_defs.vh"
module usb_cfg_fifo_ports_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DEPTH = 1 << `UCF_RX_AW;
   logic        pclk, presetn, psel, penable, pwrite, rx_wr_valid, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, rx_wr_data, prdata, tx_data, rd, push_word;
   logic [4:0]  tx_full, tx_push, rx_full, rx_empty, push_seen;
   logic [2:0]  rx_wr_ep;
   int          n_fail, n_tests;
   int          n_push = 0;
   int          cyc = 0;
   usb_cfg_fifo_ports i_usb_cfg_fifo_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_full(tx_full), .tx_push(tx_push), .tx_data(tx_data), .rx_wr_valid(rx_wr_valid), .rx_wr_ep(rx_wr_ep),
      .rx_wr_data(rx_wr_data), .rx_full(rx_full), .rx_empty(rx_empty));
   // clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // push monitor and hang guard, read away from the launching edge
   always @(negedge pclk) begin
      cyc = cyc + 1;
      if (tx_push != 5'h00) begin
         push_seen = tx_push;
         push_word = tx_data;
         n_push++;
      end
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits for pready at a rising edge, only the hang guard ends a stall
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      // answer taken at the edge where pready is sampled high
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rxw(input logic [2:0] e, input logic [31:0] d);
      @(posedge pclk);
      rx_wr_valid <= 1'b1;
      rx_wr_ep <= e;
      rx_wr_data <= d;
   endtask
   task automatic t_flags();
      apb(1'b0, `UCF_OFS_FLAGS, 32'h0);
      chk(rd, 32'h0000_0006);
      apb(1'b1, `UCF_OFS_FLAGS, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h0);
      apb(1'b0, `UCF_OFS_FLAGS, 32'h0);
      chk(rd, 32'h0000_0006);
      apb(1'b0, 12'h034, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("t_flags done");
   endtask
   task automatic t_tx();
      int p;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 12'h020 + 12'(4 * i), 32'hC0DE_0000 + i);
         chk({27'h0, push_seen}, 32'h1 << i);
         chk(push_word, 32'hC0DE_0000 + i);
         apb(1'b0, 12'h020 + 12'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      tx_full <= 5'h04;
      p = n_push;
      apb(1'b1, 12'h028, 32'h1234_5678);
      chk({31'h0, er}, 32'h1);
      chk(n_push - p, 32'h0);
      tx_full <= 5'h00;
      $display("t_tx done");
   endtask
   task automatic t_rx();
      for (int i = 0; i <= DEPTH; i++) rxw(3'h4, 32'hA000_0000 + i);
      rxw(3'h5, 32'hDEAD_0005);
      rxw(3'h1, 32'h1111_1111);
      @(posedge pclk) rx_wr_valid <= 1'b0;
      repeat (2) @(negedge pclk);
      chk({27'h0, rx_full}, 32'h10);
      chk({27'h0, rx_empty}, 32'h0D);
      for (int i = 0; i <= DEPTH; i++) begin
         apb(1'b0, 12'h030, 32'h0);
         chk(rd, (i < DEPTH) ? 32'hA000_0000 + i : 32'h0);
      end
      apb(1'b0, 12'h024, 32'h0);
      chk(rd, 32'h1111_1111);
      @(negedge pclk);
      chk({27'h0, rx_empty}, 32'h1F);
      $display("t_rx done");
   endtask
   // reset with a word queued; fifos must come back empty and flags intact
   task automatic t_reset();
      rxw(3'h0, 32'h5A5A_5A5A);
      @(posedge pclk);
      rx_wr_valid <= 1'b0;
      presetn     <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({15'h0, pready, pslverr, tx_push, rx_full, rx_empty}, 32'h1F);
      apb(1'b0, `UCF_OFS_FLAGS, 32'h0);
      chk(rd, 32'h0000_0006);
      $display("t_reset done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // reset, then the scenarios in turn
   initial begin
      {presetn, psel, penable, pwrite, rx_wr_valid} = 5'h00;
      {paddr, pwdata, rx_wr_data, rx_wr_ep, tx_full} = '0;
      {n_fail, n_tests} = '0;
      t_reset();
      t_flags();
      t_tx();
      t_reset();
      t_rx();
      final_report();
   end
endmodule // usb_cfg_fifo_ports_test
